/* logic/adc_pkg.sv */
// package: register map, codes, field layouts and types for the diagnostic checker
// assumes: apb slave with 32-bit data, one aligned word per register
package adc_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADC_OFF_DIAG_CFG = 8'h00;
  localparam logic [7:0] ADC_OFF_ACQ_CFG = 8'h04;
  localparam logic [7:0] ADC_OFF_SCAN_CTRL = 8'h08;
  localparam logic [7:0] ADC_OFF_ACC_OV_TH = 8'h0c;
  localparam logic [7:0] ADC_OFF_ACC_UV_TH = 8'h10;
  localparam logic [7:0] ADC_OFF_RESULT_A = 8'h14;
  localparam logic [7:0] ADC_OFF_RESULT_B = 8'h18;
  localparam logic [7:0] ADC_OFF_ALERT_TWO = 8'h1c;
  localparam logic [7:0] ADC_OFF_STATUS = 8'h20;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ADC_SEL_A_LSB = 0;
  localparam int ADC_SEL_B_LSB = 4;
  localparam int ADC_ACC_EN_BIT = 0;
  localparam int ADC_BIPOLAR_BIT = 1;
  localparam int ADC_SCAN_START_BIT = 0;
  localparam int ADC_SCAN_CFG_LSB = 4;
  localparam int ADC_OVSAMPL_LSB = 8;
  localparam int ADC_RESULT_LSB = 2;
  localparam int ADC_ALRT_OV_BIT = 0;
  localparam int ADC_ALRT_UV_BIT = 1;

  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] ADC_SEL_ANALOG_SUPPLY = 4'h2;
  localparam logic [3:0] ADC_SEL_ALT_REF = 4'h3;
  localparam logic [3:0] ADC_SEL_COMP_PATH = 4'h4;
  localparam logic [3:0] ADC_SEL_LOGIC_SUPPLY = 4'hd;
  localparam logic [2:0] ADC_SCAN_COMP_ONLY = 3'h1;
  localparam logic [2:0] ADC_SCAN_COMP_ADC = 3'h2;
  localparam logic [11:0] ADC_DAC_COMP_PATH = 12'h3ff;
  localparam logic [11:0] ADC_ACC_TH_RESET = 12'h3ff;
  localparam logic [31:0] ADC_ZERO_WORD = 32'h0000_0000;
  localparam int ADC_RES_W = 14;

  // ------------------------------------------------------------
  // analog front-end steering
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ADC_IN_NONE,
    ADC_IN_QUARTER_REF,
    ADC_IN_ALT_REF,
    ADC_IN_LOGIC_SUPPLY,
    ADC_IN_COMP_PREAMP
  } adc_in_t;

  typedef enum logic [1:0] {
    ADC_REF_PRIMARY,
    ADC_REF_ANALOG_SUPPLY
  } adc_ref_t;

  typedef struct packed {
    adc_in_t in_sel;
    adc_ref_t ref_sel;
    logic unipolar;
    logic amp_primary_ref;
    logic [11:0] dac_code;
    logic convert;
  } adc_afe_t;

  // converter answer
  typedef struct packed {
    logic done;
    logic [ADC_RES_W-1:0] code;
  } adc_conv_t;

endpackage

/* logic/adc_result_reg.sv */
// holds one diagnostic result word, loaded at the end of its conversion
// assumes: load pulse and data on the same clock
module adc_result_reg #(
  parameter int RES_W = adc_pkg::ADC_RES_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // load
  input wire logic load_i,
  input wire logic [RES_W-1:0] data_i,
  // stored word
  output logic [15:0] word_o
);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o <= 16'h0000;
    end else if (load_i) begin
      word_o <= {data_i, 2'b00};
    end
  end

endmodule

/* logic/adc_diag_checker.sv */
// acquisition diagnostic checker: sequences the diagnostic slot and the
// end-of-scan comparator accuracy test, apb register file
// assumes: analog converter and comparator answer through afe pins on clock_i
// Summary of operation
// - code 2 converts quarter reference on supply
// - result stored in bits fifteen down two
// - code 3 converts alternate reference
// - alternate reference check forces unipolar
// - code 13 converts scaled logic supply
// - code 4 measures comparator preamp path
// - accuracy test only for comparator scans
// - accuracy test drives reference, loads dac
// - accuracy overvoltage violation sets flag
// - accuracy undervoltage violation sets flag
// - ideal comparator at 3ffh trips overvoltage only
// - accuracy test once after final oversample
// - two independent selectors, own results
module adc_diag_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // acquisition engine
  input wire logic oversample_done_i,
  output logic acq_done_o,
  output logic scan_busy_o,
  // analog front end
  output adc_pkg::adc_afe_t afe_o,
  input wire adc_pkg::adc_conv_t conv_i,
  input wire logic comp_ov_trip_i,
  input wire logic comp_uv_trip_i
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] diag_config;
  logic [1:0] acquisition_config;
  logic [10:0] scan_control;
  logic [11:0] accuracy_overvoltage_threshold_reg;
  logic [11:0] accuracy_undervoltage_threshold_reg;
  logic accuracy_overvoltage_flag;
  logic accuracy_undervoltage_flag;
  logic [15:0] diag_result_a;
  logic [15:0] diag_result_b;
  logic [2:0] ovs_count;
  logic oversample_sync1;
  logic oversample_sync2;
  logic oversample_prev;

  typedef enum logic [2:0] {
    ADC_ST_IDLE,
    ADC_ST_SAMPLE,
    ADC_ST_DIAG_A,
    ADC_ST_DIAG_B,
    ADC_ST_ACCURACY,
    ADC_ST_DONE
  } adc_state_t;
  adc_state_t state;
  adc_state_t next_state;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire apb_access = psel_i & penable_i;
  wire apb_wr = apb_access & pwrite_i;
  wire hit_diag = paddr_i == adc_pkg::ADC_OFF_DIAG_CFG;
  wire hit_acq = paddr_i == adc_pkg::ADC_OFF_ACQ_CFG;
  wire hit_scan = paddr_i == adc_pkg::ADC_OFF_SCAN_CTRL;
  wire hit_ov = paddr_i == adc_pkg::ADC_OFF_ACC_OV_TH;
  wire hit_uv = paddr_i == adc_pkg::ADC_OFF_ACC_UV_TH;
  wire hit_res_a = paddr_i == adc_pkg::ADC_OFF_RESULT_A;
  wire hit_res_b = paddr_i == adc_pkg::ADC_OFF_RESULT_B;
  wire hit_alert = paddr_i == adc_pkg::ADC_OFF_ALERT_TWO;
  wire hit_status = paddr_i == adc_pkg::ADC_OFF_STATUS;
  wire hit_any = hit_diag | hit_acq | hit_scan | hit_ov | hit_uv | hit_res_a | hit_res_b | hit_alert | hit_status;
  wire [3:0] diag_select_a = diag_config[adc_pkg::ADC_SEL_A_LSB +: 4];
  wire [3:0] diag_select_b = diag_config[adc_pkg::ADC_SEL_B_LSB +: 4];
  wire comparator_accuracy_enable = acquisition_config[adc_pkg::ADC_ACC_EN_BIT];
  wire bipolar_cfg = acquisition_config[adc_pkg::ADC_BIPOLAR_BIT];
  wire [2:0] scan_configuration = scan_control[adc_pkg::ADC_SCAN_CFG_LSB +: 3];
  wire [2:0] ovs_log2 = scan_control[adc_pkg::ADC_OVSAMPL_LSB +: 3];
  wire start_wr = apb_wr & hit_scan & pwdata_i[adc_pkg::ADC_SCAN_START_BIT];
  wire idle = state == ADC_ST_IDLE;

  assign pready_o = 1'b1;
  assign pslverr_o = apb_access & ~hit_any;

  always_comb begin
    prdata_o = adc_pkg::ADC_ZERO_WORD;
    if (hit_diag) prdata_o[7:0] = diag_config;
    if (hit_acq) prdata_o[1:0] = acquisition_config;
    if (hit_scan) prdata_o[10:0] = scan_control;
    if (hit_ov) prdata_o[11:0] = accuracy_overvoltage_threshold_reg;
    if (hit_uv) prdata_o[11:0] = accuracy_undervoltage_threshold_reg;
    if (hit_res_a) prdata_o[15:0] = diag_result_a;
    if (hit_res_b) prdata_o[15:0] = diag_result_b;
    if (hit_alert) prdata_o[1:0] = {accuracy_undervoltage_flag, accuracy_overvoltage_flag};
    if (hit_status) prdata_o[0] = ~idle;
  end

  // ------------------------------------------------------------
  // config writes, held off while a scan runs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      diag_config <= 8'h00;
      acquisition_config <= 2'h0;
      scan_control <= 11'h000;
      accuracy_overvoltage_threshold_reg <= adc_pkg::ADC_ACC_TH_RESET;
      accuracy_undervoltage_threshold_reg <= adc_pkg::ADC_ACC_TH_RESET;
    end else if (apb_wr && idle) begin
      if (hit_diag) diag_config <= pwdata_i[7:0];
      if (hit_acq) acquisition_config <= pwdata_i[1:0];
      if (hit_scan) scan_control <= {pwdata_i[10:1], 1'b0};
      if (hit_ov) accuracy_overvoltage_threshold_reg <= pwdata_i[11:0];
      if (hit_uv) accuracy_undervoltage_threshold_reg <= pwdata_i[11:0];
    end
  end

  // ------------------------------------------------------------
  // oversample pulse from the analog sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oversample_sync1 <= 1'b0;
      oversample_sync2 <= 1'b0;
      oversample_prev <= 1'b0;
    end else begin
      oversample_sync1 <= oversample_done_i;
      oversample_sync2 <= oversample_sync1;
      oversample_prev <= oversample_sync2;
    end
  end
  wire ovs_edge = oversample_sync2 & ~oversample_prev;
  wire last_ovs = ovs_edge && (ovs_count == ovs_log2);

  // ------------------------------------------------------------
  // scan sequencer
  // ------------------------------------------------------------
  wire comp_scan = (scan_configuration == adc_pkg::ADC_SCAN_COMP_ONLY) ||
                   (scan_configuration == adc_pkg::ADC_SCAN_COMP_ADC);
  wire run_accuracy = comparator_accuracy_enable & comp_scan;

  always_comb begin
    next_state = state;
    case (state)
      ADC_ST_IDLE: if (start_wr) next_state = ADC_ST_SAMPLE;
      ADC_ST_SAMPLE: if (last_ovs) next_state = ADC_ST_DIAG_A;
      ADC_ST_DIAG_A: if (conv_i.done) next_state = ADC_ST_DIAG_B;
      ADC_ST_DIAG_B: begin
        if (conv_i.done) next_state = run_accuracy ? ADC_ST_ACCURACY : ADC_ST_DONE;
      end
      ADC_ST_ACCURACY: if (conv_i.done) next_state = ADC_ST_DONE;
      ADC_ST_DONE: next_state = ADC_ST_IDLE;
      default: next_state = ADC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ADC_ST_IDLE;
      ovs_count <= 3'h0;
    end else begin
      state <= next_state;
      if (state != ADC_ST_SAMPLE) ovs_count <= 3'h0;
      else if (ovs_edge) ovs_count <= ovs_count + 3'h1;
    end
  end

  assign scan_busy_o = ~idle;
  assign acq_done_o = state == ADC_ST_DONE;

  // ------------------------------------------------------------
  // front-end steering for the active diagnostic
  // ------------------------------------------------------------
  wire [3:0] active_sel = (state == ADC_ST_DIAG_B) ? diag_select_b : diag_select_a;
  wire in_diag = (state == ADC_ST_DIAG_A) || (state == ADC_ST_DIAG_B);

  always_comb begin
    afe_o = '0;
    afe_o.in_sel = adc_pkg::ADC_IN_NONE;
    afe_o.ref_sel = adc_pkg::ADC_REF_PRIMARY;
    afe_o.unipolar = ~bipolar_cfg;
    if (in_diag) begin
      afe_o.convert = 1'b1;
      case (active_sel)
        adc_pkg::ADC_SEL_ANALOG_SUPPLY: begin
          afe_o.in_sel = adc_pkg::ADC_IN_QUARTER_REF;
          afe_o.ref_sel = adc_pkg::ADC_REF_ANALOG_SUPPLY;
        end
        adc_pkg::ADC_SEL_ALT_REF: begin
          afe_o.in_sel = adc_pkg::ADC_IN_ALT_REF;
          afe_o.unipolar = 1'b1;
        end
        adc_pkg::ADC_SEL_LOGIC_SUPPLY: afe_o.in_sel = adc_pkg::ADC_IN_LOGIC_SUPPLY;
        adc_pkg::ADC_SEL_COMP_PATH: begin
          afe_o.in_sel = adc_pkg::ADC_IN_COMP_PREAMP;
          afe_o.amp_primary_ref = 1'b1;
          afe_o.dac_code = adc_pkg::ADC_DAC_COMP_PATH;
        end
        default: afe_o.in_sel = adc_pkg::ADC_IN_NONE;
      endcase
    end else if (state == ADC_ST_ACCURACY) begin
      afe_o.convert = 1'b1;
      afe_o.amp_primary_ref = 1'b1;
      afe_o.dac_code = accuracy_overvoltage_threshold_reg;
    end
  end

  // ------------------------------------------------------------
  // results and alert flags
  // ------------------------------------------------------------
  wire load_a = (state == ADC_ST_DIAG_A) & conv_i.done;
  wire load_b = (state == ADC_ST_DIAG_B) & conv_i.done;

  adc_result_reg #(
    .RES_W(adc_pkg::ADC_RES_W)
  ) u_result_a (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .load_i(load_a),
    .data_i(conv_i.code),
    .word_o(diag_result_a)
  );

  adc_result_reg #(
    .RES_W(adc_pkg::ADC_RES_W)
  ) u_result_b (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .load_i(load_b),
    .data_i(conv_i.code),
    .word_o(diag_result_b)
  );

  // comparator trips are the ideal answer: ov trips at 3ffh, uv does not
  wire acc_eval = (state == ADC_ST_ACCURACY) & conv_i.done;
  wire set_ov = acc_eval & comp_ov_trip_i;
  wire set_uv = acc_eval & comp_uv_trip_i;
  wire alert_wr = apb_wr & hit_alert;

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      accuracy_overvoltage_flag <= 1'b0;
      accuracy_undervoltage_flag <= 1'b0;
    end else begin
      accuracy_overvoltage_flag <= set_ov |
        (accuracy_overvoltage_flag & ~(alert_wr & pwdata_i[adc_pkg::ADC_ALRT_OV_BIT]));
      accuracy_undervoltage_flag <= set_uv |
        (accuracy_undervoltage_flag & ~(alert_wr & pwdata_i[adc_pkg::ADC_ALRT_UV_BIT]));
    end
  end

endmodule

/* bench/adc_diag_checker_sva.sv */
// checker: afe steering and acquisition handshake of the diagnostic checker
// assumes: bound to adc_diag_checker, single clock domain
module adc_diag_checker_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // observed outputs
  input wire logic acq_done_o,
  input wire logic scan_busy_o,
  input wire adc_pkg::adc_afe_t afe_o
);
  // ------------------------------------------------------------
  // shorthand
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic cv = afe_o.convert;
  wire logic in_q = cv && (afe_o.in_sel == adc_pkg::ADC_IN_QUARTER_REF);
  wire logic in_alt = cv && (afe_o.in_sel == adc_pkg::ADC_IN_ALT_REF);
  wire logic in_log = cv && (afe_o.in_sel == adc_pkg::ADC_IN_LOGIC_SUPPLY);
  wire logic in_cmp = cv && (afe_o.in_sel == adc_pkg::ADC_IN_COMP_PREAMP);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_quarter_ref; in_q |-> afe_o.ref_sel == adc_pkg::ADC_REF_ANALOG_SUPPLY; endproperty
  a_quarter_ref: assert property (p_quarter_ref) else $error("quarter ref not on supply ref");
  property p_alt_ref; in_alt |-> afe_o.ref_sel == adc_pkg::ADC_REF_PRIMARY; endproperty
  a_alt_ref: assert property (p_alt_ref) else $error("alternate ref check wrong ref");
  property p_alt_uni; in_alt |-> afe_o.unipolar; endproperty
  a_alt_uni: assert property (p_alt_uni) else $error("alternate ref check not unipolar");
  property p_logic; in_log |-> afe_o.ref_sel == adc_pkg::ADC_REF_PRIMARY; endproperty
  a_logic: assert property (p_logic) else $error("logic supply check wrong ref");
  property p_comp_path;
    in_cmp |-> afe_o.amp_primary_ref && afe_o.dac_code == adc_pkg::ADC_DAC_COMP_PATH;
  endproperty
  a_comp_path: assert property (p_comp_path) else $error("comparator path setup wrong");
  property p_idle_quiet; !scan_busy_o |-> !cv; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion outside scan");
  property p_done_pulse; acq_done_o |=> !acq_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("acq done longer than one cycle");
  property p_done_busy; acq_done_o |-> $past(scan_busy_o); endproperty
  a_done_busy: assert property (p_done_busy) else $error("acq done without scan");
endmodule

bind adc_diag_checker adc_diag_checker_sva u_sva (
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .acq_done_o(acq_done_o),
  .scan_busy_o(scan_busy_o),
  .afe_o(afe_o)
);

/* bench/adc_diag_checker_tb_top.sv */
// testbench: apb register tests, diagnostic slot and accuracy test scans
// assumes: converter and comparator answers are modelled here
module adc_diag_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ovs = 1'b0, ov_trip = 1'b0, uv_trip = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, acq_done_o, scan_busy_o, err;
  adc_pkg::adc_afe_t afe_o;
  adc_pkg::adc_conv_t conv = '0;
  int miscompares = 0, check_count = 0, conv_count = 0, cnt = 0, conv_base = 0, corr = 0;
  logic [13:0] comp_code = 14'h0000;

  always #25 clock_i = ~clock_i;

  adc_diag_checker DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .oversample_done_i(ovs), .acq_done_o(acq_done_o), .scan_busy_o(scan_busy_o),
    .afe_o(afe_o), .conv_i(conv), .comp_ov_trip_i(ov_trip), .comp_uv_trip_i(uv_trip)
  );

  // ------------------------------------------------------------
  // converter model: answers three cycles after a request
  // ------------------------------------------------------------
  // nominal codes sit inside the software pass windows
  function automatic logic [13:0] nominal(input adc_pkg::adc_in_t s);
    case (s)
      adc_pkg::ADC_IN_QUARTER_REF: return 14'h0b00;
      adc_pkg::ADC_IN_ALT_REF: return 14'h3300;
      adc_pkg::ADC_IN_LOGIC_SUPPLY: return 14'h2300;
      adc_pkg::ADC_IN_COMP_PREAMP: return 14'h2035;
      default: return 14'h0155;
    endcase
  endfunction

  function automatic logic [31:0] in_win(input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction

  always @(posedge clock_i) begin
    conv.done <= 1'b0;
    if (cnt == 0 && afe_o.convert === 1'b1 && conv.done !== 1'b1) begin
      cnt <= 3;
      conv_count <= conv_count + 1;
      conv.code <= nominal(afe_o.in_sel);
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) conv.done <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // start, feed oversample edges, wait for completion
  task automatic scan(input logic [2:0] cfg, input logic [2:0] ovl);
    int n;
    conv_base = conv_count;
    apb(1'b1, adc_pkg::ADC_OFF_SCAN_CTRL, {21'h0, ovl, 1'b0, cfg, 4'h1});
    for (int i = 0; i <= ovl; i++) begin
      ovs <= 1'b1;
      repeat (2) @(posedge clock_i);
      ovs <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (acq_done_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      miscompares++;
      end_sim();
    end
  endtask

  function automatic logic [31:0] res(input adc_pkg::adc_in_t s);
    return {16'h0, nominal(s), 2'b00};
  endfunction

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  logic [3:0] sa[4] = '{4'h2, 4'h3, 4'hd, 4'h4};
  adc_pkg::adc_in_t ia[4] = '{adc_pkg::ADC_IN_QUARTER_REF, adc_pkg::ADC_IN_ALT_REF,
                              adc_pkg::ADC_IN_LOGIC_SUPPLY, adc_pkg::ADC_IN_COMP_PREAMP};
  logic [2:0] tc[4] = '{3'h1, 3'h0, 3'h2, 3'h1};
  logic te[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic to[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic tu[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0] ta[4] = '{32'h1, 32'h0, 32'h2, 32'h0};
  int tn[4] = '{3, 2, 3, 2};
  logic [13:0] wl[4] = '{14'h0a55, 14'h3247, 14'h2147, 14'h1f3f};
  logic [13:0] wh[4] = '{14'h0bf4, 14'h341f, 14'h24b6, 14'h20bb};

  initial begin
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rchk("ov threshold", adc_pkg::ADC_OFF_ACC_OV_TH, 32'h3ff);
    rchk("uv threshold", adc_pkg::ADC_OFF_ACC_UV_TH, 32'h3ff);
    rchk("result a", adc_pkg::ADC_OFF_RESULT_A, 32'h0);
    rchk("unmapped", 8'h24, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, adc_pkg::ADC_OFF_DIAG_CFG, {24'h0, sa[3-i], sa[i]});
      apb(1'b1, adc_pkg::ADC_OFF_ACQ_CFG, 32'h2);
      scan(3'h0, 3'h0);
      chk("diag conversions", conv_count - conv_base, 32'd2);
      rchk("result a", adc_pkg::ADC_OFF_RESULT_A, res(ia[i]));
      chk("result a window", in_win(rd[15:2], wl[i], wh[i]), 32'h1);
      if (i == 3) comp_code = rd[15:2];
      rchk("result b", adc_pkg::ADC_OFF_RESULT_B, res(ia[3-i]));
      chk("result b window", in_win(rd[15:2], wl[3-i], wh[3-i]), 32'h1);
    end
    $display("test diagnostic slot done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, adc_pkg::ADC_OFF_ACQ_CFG, {31'h0, te[i]});
      apb(1'b1, adc_pkg::ADC_OFF_ALERT_TWO, 32'h3);
      ov_trip <= to[i];
      uv_trip <= tu[i];
      scan(tc[i], 3'h2);
      chk("scan conversions", conv_count - conv_base, tn[i]);
      rchk("alert two", adc_pkg::ADC_OFF_ALERT_TWO, ta[i]);
    end
    $display("test accuracy done");
    // correction goes to the accuracy thresholds only, never to aux ones
    corr = int'((real'(comp_code) - 8195.0) / 16.0);
    apb(1'b1, adc_pkg::ADC_OFF_ACC_OV_TH, 32'h3ff - 32'd18 + corr);
    apb(1'b1, adc_pkg::ADC_OFF_ACC_UV_TH, 32'h3ff + 32'd18 + corr);
    rchk("ov threshold adjusted", adc_pkg::ADC_OFF_ACC_OV_TH, 32'h3f0);
    rchk("uv threshold adjusted", adc_pkg::ADC_OFF_ACC_UV_TH, 32'h414);
    $display("test threshold adjust done");
    end_sim();
  end
endmodule
